// ===== verif/iwr_board.sv
// board-side model of reset, supply and wake-up pins
module iwr_board (
    // clock
    input wire logic clk,
    // driven pins, all idle high
    output logic reset_pin_n = 1'b1,
    output logic supply_good_signal = 1'b1,
    output logic [1:0] external_interrupt_pin = 2'h3,
    output logic wake_pin = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull reset pin or supply low six clocks, above the minimum
    task automatic drop(input bit supply);
        @(posedge clk);
        if (supply) supply_good_signal <= 1'b0;
        else reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        supply_good_signal <= 1'b1;
        reset_pin_n <= 1'b1;
    endtask : drop
    // pulse one active-low source, each level held three clocks
    task automatic fire(input int k);
        @(posedge clk);
        if (k < 2) external_interrupt_pin[k] <= 1'b0;
        else wake_pin <= 1'b0;
        repeat (3) @(posedge clk);
        external_interrupt_pin <= 2'h3;
        wake_pin <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : fire
endmodule : iwr_board

// ===== verif/iwr_chk.sv
// assertions on the ports of the idle wake-up and reset controller
module iwr_chk
    import iwr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // inputs
    input wire iwr_bus_req_t bus_req,
    input wire logic reset_pin_n,
    input wire logic supply_good_signal,
    input wire logic rtc_int,
    input wire logic [3:0] mon_src,
    // outputs
    input wire logic [31:0] bus_rdata,
    input wire logic hw_reset_n,
    input wire logic boot_start,
    input wire logic cpu_active,
    input wire logic system_clock_disable_bit,
    input wire logic sysclk_from_ext,
    input wire logic [1:0] clock_monitor_sel,
    input wire logic clock_monitor_output
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // helpers: sources one cycle back, deep wake counter
    // ----------
    logic [3:0] src_q;
    logic rtc_q;
    logic [12:0] wcnt_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_q <= 4'h0;
            rtc_q <= 1'b0;
            wcnt_q <= 13'h0;
        end else begin
            src_q <= mon_src;
            rtc_q <= rtc_int;
            if (rtc_int && !rtc_q && system_clock_disable_bit && !sysclk_from_ext) begin
                wcnt_q <= 13'h1;
            end else if (wcnt_q != 13'h0 && !cpu_active) begin
                wcnt_q <= wcnt_q + 13'h1;
            end else begin
                wcnt_q <= 13'h0;
            end
        end
    end
    // ----------
    // properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_deep_entry_halts: assert property (
        $rose(system_clock_disable_bit) |-> !cpu_active)
        else $error("cpu active on deep entry");
    a_ext_clk_wake: assert property (
        $rose(rtc_int) && sysclk_from_ext |-> ##[1:4] cpu_active)
        else $error("slow wake on external clock");
    a_light_wake: assert property (
        $rose(rtc_int) && hw_reset_n && !cpu_active && !system_clock_disable_bit
        |-> ##[1:6] cpu_active)
        else $error("slow wake from light idle");
    a_rtc_wait_min: assert property (
        wcnt_q != 13'h0 && cpu_active |-> wcnt_q >= 13'hedd)
        else $error("rtc wake too early");
    a_rtc_wait_max: assert property (wcnt_q <= 13'hef6)
        else $error("rtc wake too late");
    a_pin_resets: assert property (
        !reset_pin_n [*6] |-> ##[0:3] !hw_reset_n)
        else $error("reset pin ignored");
    a_supply_resets: assert property (
        !supply_good_signal [*6] |-> ##[0:3] !hw_reset_n)
        else $error("supply fault ignored");
    a_boot_follows: assert property (
        $rose(hw_reset_n) |-> ##[0:4] boot_start ##1 !boot_start)
        else $error("no boot pulse");
    a_monitor_follows: assert property (
        hw_reset_n && $past(hw_reset_n) && $stable(clock_monitor_sel)
        |-> clock_monitor_output == src_q[clock_monitor_sel])
        else $error("monitor output wrong");
    a_rdata_quiet: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
        else $error("read data without read");
endmodule : iwr_chk

// ===== verif/iwr_ctrl_tb_top.sv
// self-checking bench of the idle wake-up and reset controller
`include "iwr_cfg.svh"
module iwr_ctrl_tb_top
    import iwr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    iwr_bus_req_t bus_req = '0;
    logic rtc_int = 1'b0;
    logic [7:0] periph_int = 8'h00;
    logic [3:0] mon_src = 4'h0;
    logic [31:0] bus_rdata;
    logic reset_pin_n, supply_good_signal, wake_pin, hw_reset_n, boot_start, cpu_active;
    logic system_clock_disable_bit, sysclk_from_ext, clock_monitor_output, irq;
    logic [1:0] external_interrupt_pin, clock_monitor_sel;
    logic [7:0] periph_int_en;
    int n_mismatch = 0;
    int comparisons = 0;
    int n;
    initial begin
        forever #4 clk = ~clk;
    end
    iwr_board board (.clk(clk), .reset_pin_n(reset_pin_n),
        .supply_good_signal(supply_good_signal),
        .external_interrupt_pin(external_interrupt_pin), .wake_pin(wake_pin));
    iwr_ctrl uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .reset_pin_n(reset_pin_n),
        .supply_good_signal(supply_good_signal),
        .external_interrupt_pin(external_interrupt_pin), .wake_pin(wake_pin),
        .rtc_int(rtc_int), .periph_int(periph_int), .cpu_clk_sel_in(1'b0),
        .mon_src(mon_src), .hw_reset_n(hw_reset_n), .boot_start(boot_start),
        .cpu_active(cpu_active), .system_clock_disable_bit(system_clock_disable_bit),
        .sysclk_from_ext(sysclk_from_ext), .clock_monitor_sel(clock_monitor_sel),
        .clock_monitor_output(clock_monitor_output), .periph_int_en(periph_int_en),
        .irq(irq));
    // ----------
    // compare, bus and wait tasks
    // ----------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        chk(nm, exp, bus_rdata);
    endtask : rd
    task automatic wait_act(input int lim);
        n = 0;
        while (cpu_active !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("cpu_active", 32'h1, {31'h0, cpu_active});
    endtask : wait_act
    task automatic rtc_pulse();
        @(posedge clk);
        rtc_int <= 1'b1;
        repeat (2) @(posedge clk);
        rtc_int <= 1'b0;
    endtask : rtc_pulse
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // ----------
    // watchdog and test sequence
    // ----------
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        wait_act(40);
        rd(`IWR_ADDR_STAT, 32'h20, "boot status");
        rd(`IWR_ADDR_STATE, 32'h2, "state");
        rd(`IWR_ADDR_CTRL, 32'h0, "ctrl");
        rd(`IWR_ADDR_MASK, 32'h0, "mask");
        rd(8'h18, 32'h0, "unmapped");
        wr(`IWR_ADDR_STAT, 32'h3f);
        wr(`IWR_ADDR_PMSK, 32'ha5);
        rd(`IWR_ADDR_PMSK, 32'ha5, "pmsk");
        chk("pmsk out", 32'ha5, {24'h0, periph_int_en});
        for (int s = 0; s < 4; s++) begin
            wr(`IWR_ADDR_MON, s);
            mon_src <= 4'h1 << s;
            repeat (3) @(negedge clk);
            chk("monitor", {29'h0, s[1:0], 1'b1}, {29'h0, clock_monitor_sel, clock_monitor_output});
        end
        // light idle: a disabled peripheral must not wake, an enabled one must
        wr(`IWR_ADDR_CTRL, 32'h1);
        periph_int <= 8'h02;
        repeat (10) @(negedge clk);
        chk("asleep", 32'h0, {31'h0, cpu_active});
        @(posedge clk);
        periph_int <= 8'h01;
        wait_act(8);
        @(posedge clk);
        periph_int <= 8'h00;
        wr(`IWR_ADDR_STAT, 32'h3f);
        wr(`IWR_ADDR_MASK, 32'h0f);
        // each source wakes each depth, the wake pin deep idle only; deep ignores an enabled peripheral
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 4; k++) begin
                if (d == 0 && k == 2) continue;
                wr(`IWR_ADDR_CTRL, d ? 32'h6 : 32'h1);
                periph_int <= {7'h0, d[0]};
                rd(`IWR_ADDR_STATE, d ? 32'h4 : 32'h3, "idle state");
                chk("deep clock", d ? 32'h3 : 32'h0,
                    {30'h0, sysclk_from_ext, system_clock_disable_bit});
                repeat (4) @(negedge clk);
                chk("still idle", 32'h0, {31'h0, cpu_active});
                @(posedge clk);
                periph_int <= 8'h00;
                if (k == 3) rtc_pulse();
                else board.fire(k);
                wait_act(20);
                rd(`IWR_ADDR_STAT, 32'h10 | (32'h1 << k), "wake status");
                chk("irq", 32'h1, {31'h0, irq});
                wr(`IWR_ADDR_STAT, 32'h3f);
                repeat (2) @(negedge clk);
                chk("irq clear", 32'h0, {31'h0, irq});
            end
        end
        // deep idle on the rtc clock: one rtc period to wake
        wr(`IWR_ADDR_CTRL, 32'h2);
        repeat (3) @(posedge clk);
        rtc_pulse();
        wait_act(3900);
        chk("rtc wake", 32'h1, {31'h0, n > 3800 && n < 3830});
        wr(`IWR_ADDR_MASK, 32'h00);
        repeat (2) @(negedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        for (int r = 0; r < 2; r++) begin
            wr(`IWR_ADDR_MON, 32'h3);
            board.drop(r[0]);
            repeat (6) @(posedge clk);
            wait_act(40);
            rd(`IWR_ADDR_MON, 32'h0, "mon after reset");
            rd(`IWR_ADDR_STAT, 32'h20, "status after reset");
        end
        summarize();
    end
endmodule : iwr_ctrl_tb_top

bind iwr_ctrl iwr_chk chk_i (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .reset_pin_n(reset_pin_n), .supply_good_signal(supply_good_signal), .rtc_int(rtc_int),
    .mon_src(mon_src), .bus_rdata(bus_rdata), .hw_reset_n(hw_reset_n),
    .boot_start(boot_start), .cpu_active(cpu_active),
    .system_clock_disable_bit(system_clock_disable_bit), .sysclk_from_ext(sysclk_from_ext),
    .clock_monitor_sel(clock_monitor_sel), .clock_monitor_output(clock_monitor_output));

// ===== verilog/iwr_cfg.svh
// constants of the idle wake-up and reset controller
`ifndef IWR_CFG_SVH
`define IWR_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define IWR_ADDR_CTRL 8'h00
`define IWR_ADDR_STAT 8'h04
`define IWR_ADDR_MASK 8'h08
`define IWR_ADDR_PMSK 8'h0c
`define IWR_ADDR_MON 8'h10
`define IWR_ADDR_STATE 8'h14

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IWR_CTRL_LIGHT 0
`define IWR_CTRL_DEEP 1
`define IWR_CTRL_CLKSEL 2
`define IWR_EV_EXT0 0
`define IWR_EV_EXT1 1
`define IWR_EV_WAKE 2
`define IWR_EV_RTC 3
`define IWR_EV_WOKE 4
`define IWR_EV_BOOT 5
`define IWR_NEV 6
`define IWR_NPER 8

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define IWR_CTRL_RST 8'h00
`define IWR_MASK_RST 8'h00
`define IWR_PMSK_RST 8'h00
`define IWR_MON_RST 2'h0
`define IWR_SYNC_RST 5'h1c
`define IWR_RST_MIN_PERIODS 3
`define IWR_LIGHT_WAKE_PERIODS 3
`define IWR_CLK_NS 8
`define IWR_RTC_PERIOD_NS 30500
`define IWR_RTC_WAKE_CYC ((`IWR_RTC_PERIOD_NS + `IWR_CLK_NS - 1) / `IWR_CLK_NS)
`define IWR_EXT_WAKE_CYC 1

`endif

// ===== verilog/iwr_ctrl.sv
// idle wake-up and reset controller with clock monitor select
//
// Strobed register access and the address map were decided locally.
`include "iwr_cfg.svh"

module iwr_ctrl
    import iwr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire iwr_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // board pins (asynchronous)
    input wire logic reset_pin_n,
    input wire logic supply_good_signal,
    input wire logic [1:0] external_interrupt_pin,
    input wire logic wake_pin,
    // on-chip sources
    input wire logic rtc_int,
    input wire logic [`IWR_NPER-1:0] periph_int,
    // cpu clock select (unused) and clock sources for the monitor
    input wire logic cpu_clk_sel_in,
    input wire logic [3:0] mon_src,
    // outputs
    output logic hw_reset_n,
    output logic boot_start,
    output logic cpu_active,
    output logic system_clock_disable_bit,
    output logic sysclk_from_ext,
    output logic [1:0] clock_monitor_sel,
    output logic clock_monitor_output,
    output logic [`IWR_NPER-1:0] periph_int_en,
    output logic irq
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pin_raw, sync1_q, sync2_q;
    assign pin_raw = {wake_pin, external_interrupt_pin, supply_good_signal, reset_pin_n};

    // two flops per pin; first flop only feeds the second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // active-low wake pins start at their idle level, so no false edge
            sync1_q <= `IWR_SYNC_RST;
            sync2_q <= `IWR_SYNC_RST;
        end else if (clk_en) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    logic rst_comb_n;
    logic [1:0] ext_s;
    logic wake_s;
    assign rst_comb_n = sync2_q[0] & sync2_q[1];
    assign ext_s = sync2_q[3:2];
    assign wake_s = sync2_q[4];

    // ------------------------------------------------------------
    // reset qualification
    // ------------------------------------------------------------
    logic [1:0] low_cnt_q, low_cnt_d;
    logic hw_rst_n_q, hw_rst_n_d;

    // reset only recognised after three low clocks
    // shorter dips are treated as noise and dropped
    always_comb begin
        low_cnt_d = low_cnt_q;
        hw_rst_n_d = hw_rst_n_q;
        if (rst_comb_n) begin
            low_cnt_d = 2'h0;
            hw_rst_n_d = 1'b1;
        end else if (low_cnt_q == 2'(`IWR_RST_MIN_PERIODS - 1)) begin
            hw_rst_n_d = 1'b0;
        end else begin
            low_cnt_d = low_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_q <= 2'h0;
            hw_rst_n_q <= 1'b0;
        end else if (clk_en) begin
            low_cnt_q <= low_cnt_d;
            hw_rst_n_q <= hw_rst_n_d;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [`IWR_NEV-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [`IWR_NPER-1:0] pmsk_q, pmsk_d;
    logic [1:0] mon_q, mon_d;
    logic [31:0] rdata_q, rdata_d;
    logic [`IWR_NEV-1:0] ev;
    iwr_state_t st_q, st_d;

    // register writes, sticky status with set over clear
    // read data is zero outside the cycle after a read
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        pmsk_d = pmsk_q;
        mon_d = mon_q;
        stat_d = stat_q;
        rdata_d = 32'h0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                `IWR_ADDR_CTRL: ctrl_d = bus_req.wdata[7:0];
                `IWR_ADDR_STAT: stat_d = stat_q & ~bus_req.wdata[`IWR_NEV-1:0];
                `IWR_ADDR_MASK: mask_d = bus_req.wdata[`IWR_NEV-1:0];
                `IWR_ADDR_PMSK: pmsk_d = bus_req.wdata[`IWR_NPER-1:0];
                `IWR_ADDR_MON: mon_d = bus_req.wdata[1:0];
                default: ;
            endcase
        end
        stat_d = stat_d | ev;
        // idle request bits clear themselves on wake
        if (st_q == IWR_ST_WAKE) begin
            ctrl_d[`IWR_CTRL_LIGHT] = 1'b0;
            ctrl_d[`IWR_CTRL_DEEP] = 1'b0;
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                `IWR_ADDR_CTRL: rdata_d = {24'h0, ctrl_q};
                `IWR_ADDR_STAT: rdata_d = {26'h0, stat_q};
                `IWR_ADDR_MASK: rdata_d = {26'h0, mask_q};
                `IWR_ADDR_PMSK: rdata_d = {24'h0, pmsk_q};
                `IWR_ADDR_MON: rdata_d = {30'h0, mon_q};
                `IWR_ADDR_STATE: rdata_d = {29'h0, st_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `IWR_CTRL_RST;
            mask_q <= 6'h0;
            pmsk_q <= `IWR_PMSK_RST;
            mon_q <= `IWR_MON_RST;
            stat_q <= 6'h0;
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            if (!hw_rst_n_q) begin
                ctrl_q <= `IWR_CTRL_RST;
                mask_q <= 6'h0;
                pmsk_q <= `IWR_PMSK_RST;
                mon_q <= `IWR_MON_RST;
                stat_q <= 6'h0;
            end else begin
                ctrl_q <= ctrl_d;
                mask_q <= mask_d;
                pmsk_q <= pmsk_d;
                mon_q <= mon_d;
                stat_q <= stat_d;
            end
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    // wake counter spans one rtc period in system clocks
    logic [12:0] wcnt_q, wcnt_d;
    logic [1:0] ext_prev_q;
    logic wake_prev_q;
    logic per_pend, ext_edge, wake_edge, deep_wake, light_wake;
    logic [`IWR_NPER-1:0] per_act;

    // peripheral requests gated by their enables
    assign per_act = periph_int & pmsk_q;
    assign per_pend = |per_act;
    // active-low pins: falling edge is the event
    assign ext_edge = |(ext_prev_q & ~ext_s);
    assign wake_edge = wake_prev_q & ~wake_s;
    // deep idle: only pins, wake and rtc count
    assign deep_wake = ext_edge | wake_edge | rtc_int;
    // light idle: pins, rtc, or any enabled peripheral
    assign light_wake = ext_edge | rtc_int | per_pend;

    always_comb begin
        st_d = st_q;
        wcnt_d = wcnt_q;
        ev = '0;
        ev[`IWR_EV_EXT0] = ext_prev_q[0] & ~ext_s[0];
        ev[`IWR_EV_EXT1] = ext_prev_q[1] & ~ext_s[1];
        ev[`IWR_EV_WAKE] = wake_edge;
        ev[`IWR_EV_RTC] = rtc_int;
        case (st_q)
            IWR_ST_RESET: st_d = IWR_ST_BOOT;
            IWR_ST_BOOT: begin
                ev[`IWR_EV_BOOT] = 1'b1;
                st_d = IWR_ST_ACTIVE;
            end
            IWR_ST_ACTIVE: begin
                if (ctrl_q[`IWR_CTRL_DEEP]) begin
                    st_d = IWR_ST_DEEP;
                end else if (ctrl_q[`IWR_CTRL_LIGHT]) begin
                    st_d = IWR_ST_LIGHT;
                end
            end
            IWR_ST_LIGHT: begin
                if (light_wake) begin
                    st_d = IWR_ST_WAKE;
                    wcnt_d = 13'(`IWR_LIGHT_WAKE_PERIODS - 1);
                end
            end
            IWR_ST_DEEP: begin
                if (deep_wake) begin
                    st_d = IWR_ST_WAKE;
                    // one external period or one rtc period
                    wcnt_d = ctrl_q[`IWR_CTRL_CLKSEL] ? 13'(`IWR_EXT_WAKE_CYC - 1)
                        : 13'(`IWR_RTC_WAKE_CYC - 1);
                end
            end
            IWR_ST_WAKE: begin
                if (wcnt_q == 13'h0) begin
                    st_d = IWR_ST_ACTIVE;
                    ev[`IWR_EV_WOKE] = 1'b1;
                end else begin
                    wcnt_d = wcnt_q - 13'h1;
                end
            end
            default: st_d = IWR_ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= IWR_ST_RESET;
            wcnt_q <= 13'h0;
            ext_prev_q <= 2'h3;
            wake_prev_q <= 1'b1;
        end else if (clk_en) begin
            ext_prev_q <= ext_s;
            wake_prev_q <= wake_s;
            if (!hw_rst_n_q) begin
                st_q <= IWR_ST_RESET;
                wcnt_q <= 13'h0;
            end else begin
                st_q <= st_d;
                wcnt_q <= wcnt_d;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // clock switch and cpu hand-off follow the state one clock later
    logic boot_q, act_q, dis_q, ext_q, irq_q, mon_out_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_q <= 1'b0;
            act_q <= 1'b0;
            dis_q <= 1'b0;
            ext_q <= 1'b0;
            irq_q <= 1'b0;
            mon_out_q <= 1'b0;
        end else if (clk_en) begin
            boot_q <= (st_q == IWR_ST_BOOT);
            act_q <= (st_q == IWR_ST_ACTIVE);
            dis_q <= (st_q == IWR_ST_DEEP);
            ext_q <= (st_q == IWR_ST_DEEP) & ctrl_q[`IWR_CTRL_CLKSEL];
            irq_q <= |(stat_q & mask_q);
            mon_out_q <= mon_src[mon_q];
        end
    end

    assign bus_rdata = rdata_q;
    assign hw_reset_n = hw_rst_n_q;
    assign boot_start = boot_q;
    assign cpu_active = act_q;
    assign system_clock_disable_bit = dis_q;
    assign sysclk_from_ext = ext_q;
    assign clock_monitor_sel = mon_q;
    assign clock_monitor_output = mon_out_q;
    assign periph_int_en = pmsk_q;
    assign irq = irq_q;

endmodule : iwr_ctrl

// ===== verilog/iwr_pkg.sv
// types of the idle wake-up and reset controller
package iwr_pkg;

    typedef enum logic [2:0] {
        IWR_ST_RESET = 3'b000,
        IWR_ST_BOOT = 3'b001,
        IWR_ST_ACTIVE = 3'b010,
        IWR_ST_LIGHT = 3'b011,
        IWR_ST_DEEP = 3'b100,
        IWR_ST_WAKE = 3'b101
    } iwr_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } iwr_bus_req_t;

    typedef struct packed {
        logic [1:0] ext_int;
        logic wake;
        logic rtc_int;
    } iwr_wake_src_t;

endpackage : iwr_pkg
